//--- hw/sampled_acq_seq.sv
/*
 * Timing decoder and sequence controller for a four-channel acquisition
 * front end: interval counter, sample-hold gate timing, multiplexer,
 * converter start and host interrupt handshake.
 * Assumes converter busy, converter data, host command, strobe and
 * response arrive asynchronously on pins; everything runs on one clock.
 */
// What this block does
// - Whole acquisition cycle repeats every 1 ms, sampling starts each period.
// - First sample held 200 us into each interval, whatever the command.
// - Second sample held 2.5 us after the first.
// - Third hold at 50 us times command plus one, commands 0 to 6.
// - Fourth sample held 2.5 us after the third.
// - Counter value and stored command decode into gate turn-off events.
// - A nine-state controller runs mux, converter start and handshake.
// - At interval end counter clears synchronously and all gates reopen.
// - Converter start pulses for exactly one clock after the hold.
// - Interrupt asserts once busy drops and stays until host responds.
// - After each of the first three handshakes the mux advances and the sequence repeats.
// - Second sample converts at once; its hold is long past by then.
// - Third sample waits for its hold time before converting.
// - After four handovers the controller idles until interval end.
// - Exactly one multiplexer channel is selected at all times.
// - All timing derives from the single system clock.
// - Each converted sample reaches the host as a 10-bit word.
// - Interrupt is active low while valid data waits for the host.
module sampled_acq_seq #(
    parameter int unsigned INTERVAL_CYC = sampled_acq_pkg::INTERVAL_CYC
) (
    // Clock and reset
    input  wire logic                                core_clk_in,
    input  wire logic                                rst_b_in,
    // Host command port
    input  wire logic [sampled_acq_pkg::CMD_W-1:0]   cmd_in,
    input  wire logic                                cmd_strobe_in,
    output logic      [sampled_acq_pkg::CMD_W-1:0]   cmd_out,
    // Host data and interrupt handshake
    output logic      [sampled_acq_pkg::DATA_W-1:0]  host_data_out,
    output logic                                     irq_b_out,
    input  wire logic                                host_resp_b_in,
    // Converter
    output logic                                     adc_start_out,
    input  wire logic                                adc_busy_in,
    input  wire logic [sampled_acq_pkg::DATA_W-1:0]  adc_data_in,
    // Analog front end
    output logic      [sampled_acq_pkg::NUM_CH-1:0]  hold_gate_out,
    output logic      [sampled_acq_pkg::NUM_CH-1:0]  mux_sel_out
);

    localparam int unsigned CNT_W  = sampled_acq_pkg::CNT_W;
    localparam int unsigned NUM_CH = sampled_acq_pkg::NUM_CH;
    localparam int unsigned SEL_W  = sampled_acq_pkg::SEL_W;
    localparam int unsigned DATA_W = sampled_acq_pkg::DATA_W;
    localparam int unsigned CMD_W  = sampled_acq_pkg::CMD_W;
    localparam int unsigned SYNC_W = sampled_acq_pkg::SYNC_W;

    // Four-bit code space holds up to sixteen controller states
    typedef enum logic [3:0] {
        ST_WAIT_END,
        ST_WAIT_HOLD,
        ST_START,
        ST_BUSY_RISE,
        ST_BUSY_FALL,
        ST_PUSH,
        ST_WAIT_ACK,
        ST_ADVANCE,
        ST_DONE
    } seq_state_t;

    seq_state_t        state_q;
    seq_state_t        state_d;
    logic [CNT_W-1:0]  cnt_q;
    logic              interval_end;
    logic [NUM_CH-1:0] gate_q;
    logic [CNT_W-1:0]  hold_at [NUM_CH];
    logic [SEL_W-1:0]  sel_q;
    logic [NUM_CH-1:0] mux_q;
    logic [CMD_W-1:0]  cmd_q;
    logic [CMD_W-1:0]  cmd_act_q;
    logic              adc_start_q;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic              resp_b_last_q;
    logic              strobe_last_q;
    logic              busy_s;
    logic              resp_b_s;
    logic              strobe_s;
    logic [CMD_W-1:0]  cmd_s;
    logic [DATA_W-1:0] data_s;
    logic              resp_fall;
    logic              buf_in_ready;
    logic              buf_out_valid;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------

    // Two flops on every pin; only sync2_q is read downstream
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sync1_q <= sampled_acq_pkg::SYNC_RST;
            sync2_q <= sampled_acq_pkg::SYNC_RST;
        end else begin
            sync1_q <= {adc_data_in, cmd_in, cmd_strobe_in,
                        host_resp_b_in, adc_busy_in};
            sync2_q <= sync1_q;
        end
    end

    // Data and busy share one depth, so data is settled when busy drops
    assign busy_s   = sync2_q[sampled_acq_pkg::SYNC_BUSY];
    assign resp_b_s = sync2_q[sampled_acq_pkg::SYNC_RESP];
    assign strobe_s = sync2_q[sampled_acq_pkg::SYNC_STROBE];
    assign cmd_s    = sync2_q[sampled_acq_pkg::SYNC_CMD +: CMD_W];
    assign data_s   = sync2_q[sampled_acq_pkg::SYNC_DATA +: DATA_W];

    // Edge history for the response and strobe lines
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            resp_b_last_q <= 1'b1;
            strobe_last_q <= 1'b0;
        end else begin
            resp_b_last_q <= resp_b_s;
            strobe_last_q <= strobe_s;
        end
    end

    // One pop per response pulse, however long the host holds it low
    assign resp_fall = resp_b_last_q & ~resp_b_s;

    // ------------------------------------------------------------
    // Command register
    // ------------------------------------------------------------

    // Strobe loads the command; it only takes effect at the next interval
    // so a late load never strands a gate that has already passed its time
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cmd_q     <= sampled_acq_pkg::CMD_RST;
            cmd_act_q <= sampled_acq_pkg::CMD_RST;
        end else begin
            if (strobe_s && !strobe_last_q) begin
                cmd_q <= cmd_s;
            end
            if (interval_end) begin
                cmd_act_q <= cmd_q;
            end
        end
    end

    assign cmd_out = cmd_q;

    // ------------------------------------------------------------
    // Interval counter and gate timing decode
    // ------------------------------------------------------------

    // Free-running interval on the system clock
    assign interval_end = (cnt_q == CNT_W'(INTERVAL_CYC - 1));

    // Cleared synchronously at interval end
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_q <= '0;
        end else if (interval_end) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Hold instants; command 7 lands at 400 us and is left undefined
    always_comb begin
        hold_at[0] = CNT_W'(sampled_acq_pkg::HOLD1_CYC);
        hold_at[1] = CNT_W'(sampled_acq_pkg::HOLD1_CYC
                          + sampled_acq_pkg::GAP_CYC);
        hold_at[2] = CNT_W'(sampled_acq_pkg::STEP_CYC
                          * (int'(cmd_act_q) + 1));
        hold_at[3] = CNT_W'(sampled_acq_pkg::STEP_CYC
                          * (int'(cmd_act_q) + 1)
                          + sampled_acq_pkg::GAP_CYC);
    end

    // One gate flop per channel: on at interval end, off at its instant
    for (genvar g = 0; g < NUM_CH; g++) begin : g_gate
        always_ff @(posedge core_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                gate_q[g] <= sampled_acq_pkg::GATES_ON_RST[g];
            end else if (interval_end) begin
                gate_q[g] <= 1'b1;
            end else if (cnt_q == hold_at[g]) begin
                gate_q[g] <= 1'b0;
            end
        end
    end

    assign hold_gate_out = gate_q;

    // ------------------------------------------------------------
    // Sequence controller
    // ------------------------------------------------------------

    // Next state; interval end restarts the sequence from any state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_WAIT_END: begin
                state_d = ST_WAIT_END;
            end
            ST_WAIT_HOLD: begin
                if (!gate_q[sel_q]) begin
                    state_d = ST_START;
                end
            end
            ST_START: begin
                state_d = ST_BUSY_RISE;
            end
            ST_BUSY_RISE: begin
                if (busy_s) begin
                    state_d = ST_BUSY_FALL;
                end
            end
            ST_BUSY_FALL: begin
                if (!busy_s) begin
                    state_d = ST_PUSH;
                end
            end
            ST_PUSH: begin
                if (buf_in_ready) begin
                    state_d = ST_WAIT_ACK;
                end
            end
            ST_WAIT_ACK: begin
                if (resp_fall && buf_out_valid) begin
                    state_d = ST_ADVANCE;
                end
            end
            ST_ADVANCE: begin
                state_d = (sel_q == SEL_W'(NUM_CH - 1)) ? ST_DONE
                                                        : ST_WAIT_HOLD;
            end
            ST_DONE: begin
                state_d = ST_DONE;
            end
            default: begin
                state_d = ST_WAIT_END;
            end
        endcase
        if (interval_end) begin
            state_d = ST_WAIT_HOLD;
        end
    end

    // State, channel index and start pulse
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q     <= ST_WAIT_END;
            sel_q       <= '0;
            adc_start_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            adc_start_q <= (state_d == ST_START);
            if (interval_end) begin
                sel_q <= '0;
            end else if (state_q == ST_ADVANCE
                         && sel_q != SEL_W'(NUM_CH - 1)) begin
                sel_q <= sel_q + 1'b1;
            end
        end
    end

    // Mux is one-hot from reset on; stays on the last channel when done
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mux_q <= sampled_acq_pkg::MUX_FIRST;
        end else if (interval_end) begin
            mux_q <= sampled_acq_pkg::MUX_FIRST;
        end else if (state_q == ST_ADVANCE
                     && sel_q != SEL_W'(NUM_CH - 1)) begin
            mux_q <= {mux_q[NUM_CH-2:0], mux_q[NUM_CH-1]};
        end
    end

    assign mux_sel_out   = mux_q;
    assign adc_start_out = adc_start_q;

    // ------------------------------------------------------------
    // Data buffer toward the host
    // ------------------------------------------------------------

    // Two entries so a word left unanswered at interval end is not lost
    word_buffer #(
        .WIDTH (DATA_W),
        .DEPTH (sampled_acq_pkg::BUF_DEPTH)
    ) u_word_buffer (
        .core_clk_in   (core_clk_in),
        .rst_b_in      (rst_b_in),
        .in_valid_in   (state_q == ST_PUSH),
        .in_ready_out  (buf_in_ready),
        .in_data_in    (data_s),
        .out_valid_out (buf_out_valid),
        .out_ready_in  (resp_fall),
        .out_data_out  (host_data_out)
    );

    // Interrupt low exactly while a word waits for the host
    assign irq_b_out = ~buf_out_valid;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    sequence s_first_held;
        $fell(gate_q[0]);
    endsequence

    sequence s_second_held;
        ##25 $fell(gate_q[1]);
    endsequence

    interval_wrap_a: assert property (interval_end |=>
        cnt_q == '0 && gate_q == sampled_acq_pkg::GATES_ON_RST)
        else $error("interval did not restart");
    first_hold_a: assert property (
        cnt_q == CNT_W'(sampled_acq_pkg::HOLD1_CYC) |=> $fell(gate_q[0]))
        else $error("first hold missed");
    second_hold_a: assert property (s_first_held |-> s_second_held)
        else $error("second hold not 2.5 us after first");
    third_hold_a: assert property (
        cnt_q == hold_at[2] && cnt_q != '0 |=> !gate_q[2])
        else $error("third hold missed");
    fourth_hold_a: assert property (
        $fell(gate_q[2]) |-> ##25 $fell(gate_q[3]))
        else $error("fourth hold not 2.5 us after third");
    start_pulse_a: assert property (adc_start_q |=> !adc_start_q)
        else $error("start pulse longer than one cycle");
    start_held_a: assert property ($rose(adc_start_q) |->
        !$past(gate_q[sel_q]))
        else $error("conversion started before hold");
    irq_stays_a: assert property (!irq_b_out && !resp_fall |=>
        !irq_b_out)
        else $error("interrupt dropped without response");
    mux_onehot_a: assert property ($onehot(mux_q))
        else $error("multiplexer not one-hot");
    done_idle_a: assert property (state_q == ST_DONE && !interval_end |=>
        state_q == ST_DONE && adc_start_q == 1'b0)
        else $error("controller left idle early");

endmodule // sampled_acq_seq

//--- hw/word_buffer.sv
/*
 * Small FIFO holding converted words between the sequencer and the host.
 * Assumes one clock and an asynchronous active-low reset; both sides use
 * valid/ready and a word moves when both are high on a clock edge.
 */
module word_buffer #(
    parameter int unsigned WIDTH = 10,
    parameter int unsigned DEPTH = 2
) (
    // Clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             rst_b_in,
    // Filling side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Draining side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);

    localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [PTR_W:0]   count_q;
    logic             push;
    logic             pop;

    // Honest flags straight from the occupancy count
    assign in_ready_out  = (count_q != (PTR_W+1)'(DEPTH));
    assign out_valid_out = (count_q != '0);
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_ready_in & out_valid_out;
    assign out_data_out  = mem_q[rd_ptr_q];

    // Storage written only on an accepted word, so no reset is needed
    always_ff @(posedge core_clk_in) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_in;
        end
    end

    // Pointers wrap at DEPTH, which need not be a power of two
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0
                                                             : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0
                                                             : rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

endmodule // word_buffer

//--- shared/sampled_acq_pkg.sv
/*
 * Constants shared by the acquisition sequencer and its data buffer:
 * clock rate, interval and sample-hold timing, widths and reset values.
 * Assumes a single 10 MHz core clock drives every flip-flop.
 */
package sampled_acq_pkg;

    // ------------------------------------------------------------
    // Clock and timing figures, in nanoseconds
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned INTERVAL_NS   = 1000000;
    localparam int unsigned HOLD1_NS      = 200000;
    localparam int unsigned GAP_NS        = 2500;
    localparam int unsigned STEP_NS       = 50000;

    // Least times round up to whole cycles
    localparam int unsigned INTERVAL_CYC =
        (INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HOLD1_CYC =
        (HOLD1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned GAP_CYC =
        (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STEP_CYC =
        (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned CNT_W   = 14;
    localparam int unsigned CMD_W   = 3;
    localparam int unsigned DATA_W  = 10;
    localparam int unsigned NUM_CH  = 4;
    localparam int unsigned SEL_W   = 2;
    localparam int unsigned BUF_DEPTH = 2;
    localparam int unsigned SYNC_W  = 3 + CMD_W + DATA_W;

    // ------------------------------------------------------------
    // Reset values and synchroniser bit layout
    // ------------------------------------------------------------
    localparam logic [NUM_CH-1:0] GATES_ON_RST = 4'hF;
    localparam logic [NUM_CH-1:0] MUX_FIRST    = 4'h1;
    localparam logic [CMD_W-1:0]  CMD_RST      = 3'h0;
    localparam int unsigned SYNC_BUSY   = 0;
    localparam int unsigned SYNC_RESP   = 1;
    localparam int unsigned SYNC_STROBE = 2;
    localparam int unsigned SYNC_CMD    = 3;
    localparam int unsigned SYNC_DATA   = 6;
    // Response line idles high, so its stage resets high
    localparam logic [SYNC_W-1:0] SYNC_RST = 16'h0002;

endpackage

//--- verification/host_model.sv
/*
 * Host side model: answers each interrupt after a set delay.
 * Assumes one clock and the active-low interrupt of the sequencer.
 */
module host_model #(
    parameter int unsigned RESP_CYC = 20
) (
    // Clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       rst_b_in,
    // Sequencer side
    input  wire logic       irq_b_in,
    input  wire logic [9:0] data_in,
    input  wire logic [9:0] delay_in,
    output logic            host_resp_b_out,
    // Words taken, to the bench
    output logic [9:0]      word_out,
    output logic            word_stb_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------
    // Handshake
    // ------------------------------------------------
    logic [9:0] cnt_q;
    logic       act_q;

    // Read the word on the edge the pulse starts; a guard gap stops double answers
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_q <= 10'h000;
            act_q <= 1'b0;
            host_resp_b_out <= 1'b1;
            word_stb_out <= 1'b0;
            word_out <= 10'h000;
        end else begin
            word_stb_out <= 1'b0;
            cnt_q <= cnt_q + 10'h001;
            if (!act_q && irq_b_in !== 1'b0) begin
                cnt_q <= 10'h000;
            end else if (!act_q && cnt_q >= delay_in) begin
                word_out <= data_in;
                word_stb_out <= 1'b1;
                act_q <= 1'b1;
                cnt_q <= 10'h000;
                host_resp_b_out <= 1'b0;
            end else if (act_q && cnt_q == RESP_CYC - 1) begin
                host_resp_b_out <= 1'b1;
            end else if (act_q && cnt_q == RESP_CYC + 7) begin
                act_q <= 1'b0;
            end
        end
    end
endmodule // host_model

//--- verification/sampled_acq_seq_tb_top.sv
/*
 * Bench for the acquisition sequencer: converter model, monitor, tests.
 * Assumes the host model answers every interrupt it sees.
 */
module sampled_acq_seq_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------
    // Signals and models
    // ------------------------------------------------
    localparam int IV = 4200; // Room for the latest hold of command 6
    localparam int H1 = sampled_acq_pkg::HOLD1_CYC;
    localparam int G = sampled_acq_pkg::GAP_CYC;
    localparam int S = sampled_acq_pkg::STEP_CYC;
    logic       core_clk_in = 1'b0;
    logic       rst_b_in = 1'b0;
    logic [2:0] cmd = 3'h0, cmd_o;
    logic       stb = 1'b0, irq_b, resp_b, start, busy = 1'b0, wstb;
    logic [9:0] hdata, word, adata = 10'h000, dly = 10'h005;
    logic [3:0] gate, mux, gprev = 4'hF;
    logic       sprev = 1'b0, serr = 1'b0, merr = 1'b0;
    logic [3:0] msel [8];
    logic [9:0] wd [8];
    int         fall [4];
    int         st [8];
    int ecnt, rise_t, per, nrise, nst, nw, bcnt, tmo;
    int miscompares = 0, n_checks = 0;

    always #50 core_clk_in = ~core_clk_in;

    sampled_acq_seq #(.INTERVAL_CYC(IV)) i_sampled_acq_seq (
        .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .cmd_in(cmd),
        .cmd_strobe_in(stb), .cmd_out(cmd_o), .host_data_out(hdata),
        .irq_b_out(irq_b), .host_resp_b_in(resp_b), .adc_start_out(start),
        .adc_busy_in(busy), .adc_data_in(adata), .hold_gate_out(gate),
        .mux_sel_out(mux));
    host_model i_host_model (
        .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .irq_b_in(irq_b),
        .data_in(hdata), .delay_in(dly), .host_resp_b_out(resp_b),
        .word_out(word), .word_stb_out(wstb));

    // Monitor and converter; times count from the reopening of the gates
    always @(posedge core_clk_in) begin
        if (rst_b_in) begin
            ecnt <= ecnt + 1;
            gprev <= gate;
            sprev <= start;
            if (start === 1'b1 && sprev === 1'b1) serr <= 1'b1;
            if (!$onehot(mux)) merr <= 1'b1;
            if (gate === 4'hF && gprev !== 4'hF) begin
                per <= ecnt - rise_t;
                rise_t <= ecnt;
                nrise <= nrise + 1;
                nst <= 0;
                nw <= 0;
            end
            for (int i = 0; i < 4; i++)
                if (gprev[i] === 1'b1 && gate[i] === 1'b0)
                    fall[i] <= ecnt - rise_t;
            // Busy outlasts the 2.5 us gap between first and second hold
            if (start === 1'b1) begin
                st[nst[2:0]] <= ecnt - rise_t;
                msel[nst[2:0]] <= mux;
                adata <= {nst[1:0], 8'hA5};
                nst <= nst + 1;
                bcnt <= 40;
            end else if (bcnt != 0) bcnt <= bcnt - 1;
            busy <= (bcnt > 1);
            if (wstb === 1'b1) begin
                wd[nw[2:0]] <= word;
                nw <= nw + 1;
            end
        end else begin
            bcnt <= 0;
            busy <= 1'b0;
        end
    end

    // Hang guard
    always @(posedge core_clk_in) begin
        tmo <= tmo + 1;
        if (tmo == 30000) begin
            miscompares++;
            results();
        end
    end
    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (miscompares == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic do_reset();
        rst_b_in <= 1'b0;
        repeat (6) @(posedge core_clk_in);
        check(gate, 4'hF);
        check(mux, 4'h1);
        check(irq_b, 1'b1);
        check(start, 1'b0);
        check(cmd_o, 3'h0);
        rst_b_in <= 1'b1;
    endtask

    task automatic load_cmd(input logic [2:0] c);
        cmd <= c;
        repeat (3) @(posedge core_clk_in);
        stb <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        stb <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        check(cmd_o, c);
    endtask

    task automatic run_interval(input int h3, input logic [9:0] d);
        int n;
        dly <= d;
        n = nrise;
        while (nrise == n && tmo < 30000) @(posedge core_clk_in);
        repeat (IV - 40) @(posedge core_clk_in);
        if (nrise > 1) check(per, IV);
        check(fall[0], H1 + 1);
        check(fall[1], H1 + G + 1);
        check(fall[2], h3 + 1);
        check(fall[3], h3 + G + 1);
        check(st[0], H1 + 2);
        check(serr, 1'b0);
        check(st[1] > fall[1], 1'b1);
        check(st[2] >= fall[2] + 1, 1'b1);
        check(nst, 4);
        check(nw, 4);
        check(merr, 1'b0);
        for (int k = 0; k < 4; k++) begin
            check(msel[k], 4'h1 << k);
            check(wd[k], {k[1:0], 8'hA5});
        end
    endtask

    // Latest command with a quick host, then earliest with a slow host
    initial begin
        do_reset();
        load_cmd(3'h6);
        run_interval(S * 7, 10'h005);
        load_cmd(3'h0);
        run_interval(S, 10'h0C8);
        repeat (H1 + 100) @(posedge core_clk_in);
        do_reset();
        results();
    end
endmodule // sampled_acq_seq_tb_top
